// >>> core/sct_pkg.sv
// Register map, field positions, reset values and mode codes of the single-channel timer.
package sct_pkg;
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] IRQ_EN_OFF   = 8'h04;
  localparam logic [7:0] FLAGS_OFF    = 8'h08;
  localparam logic [7:0] SOFT_OFF     = 8'h0c;
  localparam logic [7:0] CH_CFG_OFF   = 8'h10;
  localparam logic [7:0] COUNT_OFF    = 8'h14;
  localparam logic [7:0] PRESCALE_OFF = 8'h18;
  localparam logic [7:0] RELOAD_OFF   = 8'h1c;
  localparam logic [7:0] CH_VAL_OFF   = 8'h20;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_INH = 1;
  localparam int CTRL_SRC = 2;
  localparam int IRQ_UPD  = 0;
  localparam int IRQ_CH   = 1;
  localparam int FLG_UPD  = 0;
  localparam int FLG_CH   = 1;
  localparam int FLG_OVR  = 9;
  localparam int SOFT_UPD = 0;
  localparam int SOFT_CH  = 1;
  localparam int CFG_SRC  = 0;
  localparam int CFG_BUF  = 2;
  localparam int CFG_MODE = 4;
  localparam int CFG_FLT  = 8;
  localparam int CFG_CPSC = 12;
  localparam int CFG_IOEN = 16;
  localparam int CFG_POL  = 17;
  localparam int CFG_NPOL = 19;

  localparam logic [15:0] RELOAD_RST   = 16'hffff;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  localparam logic [15:0] CH_VAL_RST   = 16'h0000;

  localparam logic [2:0] MODE_FROZEN = 3'h0;
  localparam logic [2:0] MODE_SET    = 3'h1;
  localparam logic [2:0] MODE_CLR    = 3'h2;
  localparam logic [2:0] MODE_TOG    = 3'h3;
  localparam logic [2:0] MODE_FLO    = 3'h4;
  localparam logic [2:0] MODE_FHI    = 3'h5;
  localparam logic [2:0] MODE_PWM0   = 3'h6;
  localparam logic [2:0] MODE_PWM1   = 3'h7;

  localparam logic [1:0] SRC_NONE  = 2'h0;
  localparam logic [1:0] SRC_OWN   = 2'h1;
  localparam logic [1:0] SRC_OTHER = 2'h2;
  localparam logic [1:0] SRC_TRIG  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sct_pkg

// >>> core/sct_timer.sv
// Single-channel capture/compare timer with an AXI4-Lite register slave.
// Functional notes
// - Sixteen-bit counter counts upward only.
// - Prescaler runs from kernel clock while running.
// - Prescale factor is register value plus one.
// - New prescale value applies at update event.
// - Counter counts zero to limit, then wraps.
// - Overflow past limit raises update event.
// - Soft trigger clears counter, raises update event.
// - Update inhibit suppresses all update events.
// - Update event loads limit and prescale shadows.
// - Input synchronised then digitally filtered.
// - Rising, falling or both edges selectable.
// - Capture source: own, other input, trigger.
// - Nonzero source means input mode, value read-only.
// - Capture prescaler divides detected input events.
// - Capture loads counter, sets flag, interrupts.
// - Capture while flag set sets overrun.
// - Soft channel event sets flag, interrupts.
// - Compare match sets flag, updates prepare level.
// - Mode zero holds level, one sets high.
// - Modes four, five force level low, high.
// - Pin follows level, inverted by polarity, enabled.
// - PWM modes: period from limit, duty value.
// - PWM0 value above limit stays active.
// - PWM0 value zero stays inactive.
// - Buffer enable defers value writes to update.
// - Update flag sets, stays until software clears.
// - Source select limits update flag to overflow.
// - Inhibited soft trigger still resets counter, prescaler.
`timescale 1ns/100ps
module sct_timer (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write
  input  wire logic        axi_awvalid,
  output logic             axi_awready,
  input  wire logic [7:0]  axi_awaddr,
  input  wire logic        axi_wvalid,
  output logic             axi_wready,
  input  wire logic [31:0] axi_wdata,
  input  wire logic [3:0]  axi_wstrb,
  output logic             axi_bvalid,
  input  wire logic        axi_bready,
  output logic [1:0]       axi_bresp,
  // AXI4-Lite read
  input  wire logic        axi_arvalid,
  output logic             axi_arready,
  input  wire logic [7:0]  axi_araddr,
  output logic             axi_rvalid,
  input  wire logic        axi_rready,
  output logic [31:0]      axi_rdata,
  output logic [1:0]       axi_rresp,
  // Channel pins and trigger
  input  wire logic        channel_input_pin,
  input  wire logic        other_channel_input,
  input  wire logic        internal_trigger,
  output logic             channel_output_pin,
  output logic             channel_output_oe,
  // Interrupt
  output logic             timer_irq
);

  typedef struct packed {
    logic        counter_run;
    logic        update_inhibit;
    logic        update_source_sel;
    logic        update_irq_enable;
    logic        channel_irq_enable;
    logic        update_event_flag;
    logic        channel_event_flag;
    logic        channel_overrun_flag;
    logic [1:0]  channel_source_sel;
    logic        compare_buffer_enable;
    logic [2:0]  compare_output_mode;
    logic [3:0]  input_filter_cfg;
    logic [1:0]  capture_div;
    logic        channel_io_enable;
    logic        capture_polarity_sel;
    logic        capture_neg_polarity;
    logic [15:0] cnt;
    logic [15:0] psc_cnt;
    logic [15:0] psc_pre;
    logic [15:0] psc_act;
    logic [15:0] rel_pre;
    logic [15:0] rel_act;
    logic [15:0] chval;
    logic [15:0] chval_pre;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [3:0]  flt_cnt;
    logic        filt;
    logic        filt_d;
    logic [2:0]  evt_cnt;
    logic        prep;
    logic        pin;
    logic        oe;
    logic        irq;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } sct_state_s;

  sct_state_s  r;
  sct_state_s  next_r;
  logic        tick;
  logic        ovf;
  logic        uev;
  logic        soft_upd;
  logic        soft_ch;
  logic        do_wr;
  logic        in_mode;
  logic        raw;
  logic        edge_hit;
  logic        cap_evt;
  logic        match;
  logic [31:0] wv;

  function automatic logic sct_mapped(input logic [7:0] a);
    case (a)
      sct_pkg::CTRL_OFF, sct_pkg::IRQ_EN_OFF, sct_pkg::FLAGS_OFF, sct_pkg::SOFT_OFF,
      sct_pkg::CH_CFG_OFF, sct_pkg::COUNT_OFF, sct_pkg::PRESCALE_OFF,
      sct_pkg::RELOAD_OFF, sct_pkg::CH_VAL_OFF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : sct_mapped

  // Soft event bits always read as zero; they exist only as write pulses.
  function automatic logic [31:0] sct_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      sct_pkg::CTRL_OFF: begin
        v[sct_pkg::CTRL_RUN] = r.counter_run;
        v[sct_pkg::CTRL_INH] = r.update_inhibit;
        v[sct_pkg::CTRL_SRC] = r.update_source_sel;
      end
      sct_pkg::IRQ_EN_OFF: begin
        v[sct_pkg::IRQ_UPD] = r.update_irq_enable;
        v[sct_pkg::IRQ_CH]  = r.channel_irq_enable;
      end
      sct_pkg::FLAGS_OFF: begin
        v[sct_pkg::FLG_UPD] = r.update_event_flag;
        v[sct_pkg::FLG_CH]  = r.channel_event_flag;
        v[sct_pkg::FLG_OVR] = r.channel_overrun_flag;
      end
      sct_pkg::CH_CFG_OFF: begin
        v[sct_pkg::CFG_SRC +: 2]  = r.channel_source_sel;
        v[sct_pkg::CFG_BUF]       = r.compare_buffer_enable;
        v[sct_pkg::CFG_MODE +: 3] = r.compare_output_mode;
        v[sct_pkg::CFG_FLT +: 4]  = r.input_filter_cfg;
        v[sct_pkg::CFG_CPSC +: 2] = r.capture_div;
        v[sct_pkg::CFG_IOEN]      = r.channel_io_enable;
        v[sct_pkg::CFG_POL]       = r.capture_polarity_sel;
        v[sct_pkg::CFG_NPOL]      = r.capture_neg_polarity;
      end
      sct_pkg::COUNT_OFF:    v[15:0] = r.cnt;
      sct_pkg::PRESCALE_OFF: v[15:0] = r.psc_pre;
      sct_pkg::RELOAD_OFF:   v[15:0] = r.rel_pre;
      sct_pkg::CH_VAL_OFF:   v[15:0] = r.chval;
      default:               v = 32'h0000_0000;
    endcase
    return v;
  endfunction : sct_read

  function automatic logic [31:0] sct_merge(input logic [31:0] o, input logic [31:0] w,
                                            input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = w[8*i +: 8];
      end
    end
    return m;
  endfunction : sct_merge

  always_comb begin
    next_r   = r;
    soft_upd = 1'b0;
    soft_ch  = 1'b0;
    in_mode  = r.channel_source_sel != sct_pkg::SRC_NONE;
    do_wr    = r.aw_got && r.w_got && !r.bvalid;
    wv       = sct_merge(sct_read(r.waddr), r.wdata, r.wstrb);
    if (axi_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.waddr  = axi_awaddr;
    end
    if (axi_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = axi_wdata;
      next_r.wstrb = axi_wstrb;
    end
    if (r.bvalid && axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (do_wr) begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = sct_mapped(r.waddr) ? sct_pkg::RESP_OKAY : sct_pkg::RESP_SLVERR;
      case (r.waddr)
        sct_pkg::CTRL_OFF: begin
          next_r.counter_run       = wv[sct_pkg::CTRL_RUN];
          next_r.update_inhibit    = wv[sct_pkg::CTRL_INH];
          next_r.update_source_sel = wv[sct_pkg::CTRL_SRC];
        end
        sct_pkg::IRQ_EN_OFF: begin
          next_r.update_irq_enable  = wv[sct_pkg::IRQ_UPD];
          next_r.channel_irq_enable = wv[sct_pkg::IRQ_CH];
        end
        sct_pkg::FLAGS_OFF: begin
          // Writing zero clears a flag; a one leaves it, so no flag is lost by a
          // read-modify-write race.
          next_r.update_event_flag    = r.update_event_flag & wv[sct_pkg::FLG_UPD];
          next_r.channel_event_flag   = r.channel_event_flag & wv[sct_pkg::FLG_CH];
          next_r.channel_overrun_flag = r.channel_overrun_flag & wv[sct_pkg::FLG_OVR];
        end
        sct_pkg::SOFT_OFF: begin
          soft_upd = wv[sct_pkg::SOFT_UPD];
          soft_ch  = wv[sct_pkg::SOFT_CH];
        end
        sct_pkg::CH_CFG_OFF: begin
          next_r.channel_source_sel    = wv[sct_pkg::CFG_SRC +: 2];
          next_r.compare_buffer_enable = wv[sct_pkg::CFG_BUF];
          next_r.compare_output_mode   = wv[sct_pkg::CFG_MODE +: 3];
          next_r.input_filter_cfg      = wv[sct_pkg::CFG_FLT +: 4];
          next_r.capture_div           = wv[sct_pkg::CFG_CPSC +: 2];
          next_r.channel_io_enable     = wv[sct_pkg::CFG_IOEN];
          next_r.capture_polarity_sel  = wv[sct_pkg::CFG_POL];
          next_r.capture_neg_polarity  = wv[sct_pkg::CFG_NPOL];
        end
        sct_pkg::PRESCALE_OFF: next_r.psc_pre = wv[15:0];
        sct_pkg::RELOAD_OFF:   next_r.rel_pre = wv[15:0];
        sct_pkg::CH_VAL_OFF: begin
          if (!in_mode) begin
            next_r.chval_pre = wv[15:0];
            if (!r.compare_buffer_enable) begin
              next_r.chval = wv[15:0];
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (axi_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = sct_read(axi_araddr);
      next_r.rresp  = sct_mapped(axi_araddr) ? sct_pkg::RESP_OKAY : sct_pkg::RESP_SLVERR;
    end else if (r.rvalid && axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready  = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;

    // Counting chain.
    tick = r.counter_run && (r.psc_cnt == r.psc_act);
    ovf  = tick && (r.cnt == r.rel_act);
    if (r.counter_run) begin
      next_r.psc_cnt = tick ? 16'h0000 : r.psc_cnt + 16'h0001;
    end
    if (tick) begin
      next_r.cnt = ovf ? 16'h0000 : r.cnt + 16'h0001;
    end
    if (soft_upd) begin
      next_r.cnt     = 16'h0000;
      next_r.psc_cnt = 16'h0000;
    end
    uev = (ovf || soft_upd) && !r.update_inhibit;
    if (uev) begin
      next_r.psc_act = r.psc_pre;
      next_r.rel_act = r.rel_pre;
      if (r.compare_buffer_enable && !in_mode) begin
        next_r.chval = r.chval_pre;
      end
      if (ovf || !r.update_source_sel) begin
        next_r.update_event_flag = 1'b1;
      end
    end

    // Input stage: the second synchroniser stage is the first one logic reads.
    next_r.sync1 = {other_channel_input, channel_input_pin};
    next_r.sync2 = r.sync1;
    unique case (r.channel_source_sel)
      sct_pkg::SRC_OTHER: raw = r.sync2[1];
      sct_pkg::SRC_TRIG:  raw = internal_trigger;
      sct_pkg::SRC_OWN:   raw = r.sync2[0];
      sct_pkg::SRC_NONE:  raw = r.sync2[0];
    endcase
    // A change must persist for input_filter_cfg + 1 samples before it is taken.
    if (raw == r.filt) begin
      next_r.flt_cnt = 4'h0;
    end else if (r.flt_cnt >= r.input_filter_cfg) begin
      next_r.filt    = raw;
      next_r.flt_cnt = 4'h0;
    end else begin
      next_r.flt_cnt = r.flt_cnt + 4'h1;
    end
    next_r.filt_d = r.filt;
    if (r.capture_neg_polarity) begin
      edge_hit = r.filt ^ r.filt_d;
    end else if (r.capture_polarity_sel) begin
      edge_hit = !r.filt && r.filt_d;
    end else begin
      edge_hit = r.filt && !r.filt_d;
    end
    cap_evt = 1'b0;
    if (in_mode && r.channel_io_enable && edge_hit) begin
      if (r.evt_cnt == 3'((4'h1 << r.capture_div) - 4'h1)) begin
        next_r.evt_cnt = 3'h0;
        cap_evt        = 1'b1;
      end else begin
        next_r.evt_cnt = r.evt_cnt + 3'h1;
      end
    end
    if (cap_evt) begin
      next_r.chval = r.cnt;
      if (r.channel_event_flag) begin
        next_r.channel_overrun_flag = 1'b1;
      end
    end

    // Output stage.
    match = !in_mode && (tick || soft_upd) && (next_r.cnt == r.chval);
    if (cap_evt || match || soft_ch) begin
      next_r.channel_event_flag = 1'b1;
    end
    unique case (r.compare_output_mode)
      sct_pkg::MODE_FROZEN: next_r.prep = r.prep;
      sct_pkg::MODE_SET:    next_r.prep = match ? 1'b1 : r.prep;
      sct_pkg::MODE_CLR:    next_r.prep = match ? 1'b0 : r.prep;
      sct_pkg::MODE_TOG:    next_r.prep = match ? !r.prep : r.prep;
      sct_pkg::MODE_FLO:    next_r.prep = 1'b0;
      sct_pkg::MODE_FHI:    next_r.prep = 1'b1;
      // Compare with less-than so a value above the limit stays active and zero
      // stays inactive without special cases.
      sct_pkg::MODE_PWM0:   next_r.prep = r.cnt < r.chval;
      sct_pkg::MODE_PWM1:   next_r.prep = r.cnt >= r.chval;
    endcase
    next_r.pin = r.channel_io_enable && (r.prep ^ r.capture_polarity_sel);
    next_r.oe  = r.channel_io_enable;
    next_r.irq = (next_r.update_event_flag && next_r.update_irq_enable)
               || (next_r.channel_event_flag && next_r.channel_irq_enable);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r         <= '0;
      r.rel_pre <= sct_pkg::RELOAD_RST;
      r.rel_act <= sct_pkg::RELOAD_RST;
      r.psc_pre <= sct_pkg::PRESCALE_RST;
      r.psc_act <= sct_pkg::PRESCALE_RST;
      r.chval   <= sct_pkg::CH_VAL_RST;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign axi_awready        = r.awready;
  assign axi_wready         = r.wready;
  assign axi_bvalid         = r.bvalid;
  assign axi_bresp          = r.bresp;
  assign axi_arready        = r.arready;
  assign axi_rvalid         = r.rvalid;
  assign axi_rdata          = r.rdata;
  assign axi_rresp          = r.rresp;
  assign channel_output_pin = r.pin;
  assign channel_output_oe  = r.oe;
  assign timer_irq          = r.irq;

  default clocking sct_cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_WRAP: assert property (ovf |=> r.cnt == 16'h0000)
    else $error("Counter did not wrap after the limit.");
  AST_STEP: assert property (tick && !ovf && !soft_upd |=> r.cnt == $past(r.cnt) + 16'h0001)
    else $error("Counter did not step up by one.");
  AST_FREEZE: assert property (!r.counter_run && !soft_upd |=> $stable(r.cnt))
    else $error("Stopped counter changed.");
  AST_PSC_HOLD: assert property (!uev |=> $stable(r.psc_act))
    else $error("Active prescaler changed without update.");
  AST_SHADOW: assert property (uev |=> r.psc_act == $past(r.psc_pre) && r.rel_act == $past(r.rel_pre))
    else $error("Shadows not loaded on update.");
  AST_INHIBIT: assert property (r.update_inhibit |=> $stable(r.psc_act) && $stable(r.rel_act))
    else $error("Shadows loaded while updates are inhibited.");
  AST_SOFT: assert property (soft_upd |=> r.cnt == 16'h0000 && r.psc_cnt == 16'h0000)
    else $error("Soft trigger did not clear counter and prescaler.");
  AST_CAPTURE: assert property (cap_evt |=> r.chval == $past(r.cnt) && r.channel_event_flag)
    else $error("Capture did not load value and flag.");
  AST_OVERRUN: assert property (cap_evt && r.channel_event_flag |=> r.channel_overrun_flag)
    else $error("Overrun not flagged.");
  AST_PWM0_ZERO: assert property (r.compare_output_mode == sct_pkg::MODE_PWM0 && r.chval == 16'h0000
    |=> !r.prep) else $error("PWM0 with zero value went active.");
  AST_PWM0_FULL: assert property (r.compare_output_mode == sct_pkg::MODE_PWM0 && r.chval > r.rel_act
    && r.cnt <= r.rel_act |=> r.prep) else $error("PWM0 above limit went inactive.");
  AST_PIN: assert property (##1 r.oe == $past(r.channel_io_enable)
    && (r.pin == ($past(r.channel_io_enable) && ($past(r.prep) ^ $past(r.capture_polarity_sel)))))
    else $error("Output pin does not follow prepare level.");
  AST_RO_VAL: assert property (do_wr && r.waddr == sct_pkg::CH_VAL_OFF && in_mode && !cap_evt
    |=> $stable(r.chval)) else $error("Input-mode value was overwritten.");
  AST_UFLAG: assert property (uev && (ovf || !r.update_source_sel) |=> r.update_event_flag)
    else $error("Update flag not set.");

endmodule : sct_timer

// >>> verif/sct_sig_src.sv
// Signal source that drives the timer's channel input with clean pulses.
`timescale 1ns/100ps
module sct_sig_src (
  // Clock and command
  input  wire logic       core_clk,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  // Channel pin
  output logic            channel_input_pin
);
  int left = 0;

  always @(posedge core_clk) begin
    if (fire)
      left <= width;
    else if (left > 0)
      left <= left - 1;
  end

  // The bench's 16-cycle pulses are as long as the longest filter window, so no edge is swallowed.
  assign channel_input_pin = (left > 0);
endmodule : sct_sig_src

// >>> verif/tb_single_channel_capture_compare_timer.sv
// Self-checking bench for the single-channel timer against a counter model.
`timescale 1ns/100ps
module tb_single_channel_capture_compare_timer;
  logic        core_clk = 0, sys_rst = 1, fire = 0, other_in = 0, trig = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, width = 8'h10;
  logic [31:0] wdata = 0, rdata, rv;
  logic        awready, wready, bvalid, arready, rvalid, pin_in, pin_out, pin_oe, irq;
  logic [1:0]  bresp, rresp, rs;
  int          cyc = 0, miscompares = 0, checked = 0, seed = 32'h553a8aa5;
  int          cnt, pc, psc_a, rld_a, psc_p, rld_p, uf, es, te, k, mt, cv;

  sct_timer dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .axi_awvalid(awvalid), .axi_awready(awready), .axi_awaddr(awaddr),
    .axi_wvalid(wvalid), .axi_wready(wready), .axi_wdata(wdata), .axi_wstrb(4'hf),
    .axi_bvalid(bvalid), .axi_bready(bready), .axi_bresp(bresp),
    .axi_arvalid(arvalid), .axi_arready(arready), .axi_araddr(araddr),
    .axi_rvalid(rvalid), .axi_rready(rready), .axi_rdata(rdata), .axi_rresp(rresp),
    .channel_input_pin(pin_in), .other_channel_input(other_in), .internal_trigger(trig),
    .channel_output_pin(pin_out), .channel_output_oe(pin_oe), .timer_irq(irq));

  sct_sig_src src_u (.core_clk(core_clk), .fire(fire), .width(width),
    .channel_input_pin(pin_in));

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    other_in <= 1'($random(seed));
    trig <= 1'($random(seed));
  end

  task automatic cmp_reg(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic exp, input logic got);
    cmp_reg({31'h0, exp}, {31'h0, got});
  endtask : cmp_pin

  // The edge of the later half's hand-over is kept in te; the write lands one edge later.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge core_clk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    bready <= 1;
    do begin
      @(posedge core_clk);
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 0;
        te = cyc;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 0;
        te = cyc;
      end
    end while (!(ad && wd));
    do @(posedge core_clk); while (!bvalid);
    bready <= 0;
    rs = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 0;
    rv = rdata;
    rs = rresp;
  endtask : rd

  task automatic adv(input int n, input logic inh);
    repeat (n) begin
      if (pc == psc_a) begin
        pc = 0;
        if (cnt == rld_a) begin
          cnt = 0;
          if (!inh) begin
            psc_a = psc_p;
            rld_a = rld_p;
            uf = 1;
          end
        end else
          cnt++;
        mt += (cnt == cv);
      end else
        pc++;
    end
  endtask : adv

  task automatic soft_upd(input logic inh, input logic src);
    wr(sct_pkg::SOFT_OFF, 32'h1);
    cnt = 0;
    pc = 0;
    if (!inh) begin
      psc_a = psc_p;
      rld_a = rld_p;
      uf = uf | !src;
    end
  endtask : soft_upd

  task automatic span(input logic [2:0] c, input int idle);
    wr(sct_pkg::CTRL_OFF, {29'h0, c | 3'h1});
    es = te;
    repeat (idle) @(posedge core_clk);
    wr(sct_pkg::CTRL_OFF, {29'h0, c});
    adv(te - es, c[1]);
    rd(sct_pkg::COUNT_OFF);
    cmp_reg(cnt, rv);
    rd(sct_pkg::FLAGS_OFF);
    cmp_reg(uf, rv);
    wr(sct_pkg::FLAGS_OFF, 32'h0);
    uf = 0;
  endtask : span

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    #3000000;
    miscompares++;
    final_report();
  end

  initial begin
    cnt = 0; pc = 0; psc_a = 0; psc_p = 0; rld_a = 'hffff; rld_p = 'hffff; uf = 0;
    mt = 0;
    cv = -1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 0;
    rd(sct_pkg::RELOAD_OFF);
    cmp_reg(32'hffff, rv);
    rd(8'h40);
    cmp_reg(sct_pkg::RESP_SLVERR, rs);
    wr(8'h44, 32'h1);
    cmp_reg(sct_pkg::RESP_SLVERR, rs);
    wr(sct_pkg::CH_VAL_OFF, 32'hffff);
    repeat (4) begin
      wr(sct_pkg::CTRL_OFF, 32'h0);
      rld_p = 4 + ($random(seed) & 15);
      psc_p = $random(seed) & 3;
      wr(sct_pkg::RELOAD_OFF, rld_p);
      wr(sct_pkg::PRESCALE_OFF, psc_p);
      soft_upd(0, 0);
      rd(sct_pkg::FLAGS_OFF);
      cmp_reg(uf, rv);
      wr(sct_pkg::FLAGS_OFF, 32'h0);
      uf = 0;
      span(3'h0, 20 + ($random(seed) & 63));
      psc_p = psc_p ^ 2;
      wr(sct_pkg::PRESCALE_OFF, psc_p);
      span(3'h0, $random(seed) & 31);
      span(3'h2, 40);
      soft_upd(1, 0);
      rd(sct_pkg::COUNT_OFF);
      cmp_reg(32'h0, rv);
      wr(sct_pkg::CTRL_OFF, 32'h4);
      soft_upd(0, 1);
      rd(sct_pkg::FLAGS_OFF);
      cmp_reg(uf, rv);
      span(3'h4, 30);
    end
    wr(sct_pkg::IRQ_EN_OFF, 32'h2);
    wr(sct_pkg::SOFT_OFF, 32'h2);
    rd(sct_pkg::FLAGS_OFF);
    cmp_reg(32'h2, rv);
    cmp_pin(1, irq);
    wr(sct_pkg::FLAGS_OFF, 32'h0);
    cmp_pin(0, irq);
    for (int i = 0; i < 4; i++) begin
      wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | ((4 + i % 2) << sct_pkg::CFG_MODE)
        | ((i / 2) << sct_pkg::CFG_POL));
      repeat (2) @(posedge core_clk);
      cmp_pin((i % 2) ^ (i / 2), pin_out);
      cmp_pin(1, pin_oe);
    end
    for (int i = 0; i < 4; i++) begin
      wr(sct_pkg::CH_VAL_OFF, (i % 2) ? 32'hffff : 32'h0);
      wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | ((6 + i / 2) << sct_pkg::CFG_MODE));
      wr(sct_pkg::CTRL_OFF, 32'h1);
      repeat (30) begin
        @(posedge core_clk);
        cmp_pin((i % 2) ^ (i / 2), pin_out);
      end
      wr(sct_pkg::CTRL_OFF, 32'h0);
    end
    wr(sct_pkg::CH_CFG_OFF, 4 << sct_pkg::CFG_MODE);
    repeat (2) @(posedge core_clk);
    cmp_pin(0, pin_oe);
    wr(sct_pkg::CH_VAL_OFF, 32'h3);
    wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | (1 << sct_pkg::CFG_MODE));
    wr(sct_pkg::FLAGS_OFF, 32'h0);
    wr(sct_pkg::SOFT_OFF, 32'h1);
    wr(sct_pkg::CTRL_OFF, 32'h1);
    repeat (80) @(posedge core_clk);
    wr(sct_pkg::CTRL_OFF, 32'h0);
    rd(sct_pkg::FLAGS_OFF);
    cmp_reg(32'h2, rv & 32'h2);
    cmp_pin(1, pin_out);
    // Clear, then toggle: the model counts the matches so the toggle parity is known.
    cv = 3;
    for (int i = 2; i < 4; i++) begin
      wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | (i << sct_pkg::CFG_MODE));
      soft_upd(0, 0);
      mt = 0;
      wr(sct_pkg::CTRL_OFF, 32'h1);
      es = te;
      repeat (20 + ($random(seed) & 63)) @(posedge core_clk);
      wr(sct_pkg::CTRL_OFF, 32'h0);
      adv(te - es, 0);
      repeat (2) @(posedge core_clk);
      cmp_pin((i == 3) ? mt % 2 : 0, pin_out);
    end
    wr(sct_pkg::CH_CFG_OFF, 1 << sct_pkg::CFG_BUF);
    rd(sct_pkg::CH_VAL_OFF);
    k = rv;
    wr(sct_pkg::CH_VAL_OFF, k ^ 32'h5a);
    rd(sct_pkg::CH_VAL_OFF);
    cmp_reg(k, rv);
    soft_upd(0, 0);
    rd(sct_pkg::CH_VAL_OFF);
    cmp_reg(k ^ 32'h5a, rv);
    wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | sct_pkg::SRC_OWN);
    wr(sct_pkg::FLAGS_OFF, 32'h0);
    wr(sct_pkg::CTRL_OFF, 32'h1);
    rd(sct_pkg::CH_VAL_OFF);
    k = rv;
    wr(sct_pkg::CH_VAL_OFF, 32'h1234);
    rd(sct_pkg::CH_VAL_OFF);
    cmp_reg(k, rv);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      fire <= 1;
      @(posedge core_clk);
      fire <= 0;
      repeat (40) @(posedge core_clk);
      rd(sct_pkg::FLAGS_OFF);
      cmp_reg(i ? 32'h202 : 32'h2, rv & 32'h202);
    end
    // Both edges with a divide-by-two: one pulse must give exactly one capture.
    wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN) | sct_pkg::SRC_OWN
      | (1 << sct_pkg::CFG_NPOL) | (1 << sct_pkg::CFG_CPSC) | (3 << sct_pkg::CFG_FLT));
    wr(sct_pkg::FLAGS_OFF, 32'h0);
    @(posedge core_clk);
    fire <= 1;
    @(posedge core_clk);
    fire <= 0;
    repeat (40) @(posedge core_clk);
    rd(sct_pkg::FLAGS_OFF);
    cmp_reg(32'h2, rv & 32'h202);
    // The other input and the trigger toggle at random, so both flags must be up.
    for (int i = 0; i < 2; i++) begin
      wr(sct_pkg::CH_CFG_OFF, (1 << sct_pkg::CFG_IOEN)
        | (i ? sct_pkg::SRC_TRIG : sct_pkg::SRC_OTHER));
      wr(sct_pkg::FLAGS_OFF, 32'h0);
      repeat (40) @(posedge core_clk);
      rd(sct_pkg::FLAGS_OFF);
      cmp_reg(32'h202, rv & 32'h202);
    end
    wr(sct_pkg::CTRL_OFF, 32'h0);
    final_report();
  end
endmodule : tb_single_channel_capture_compare_timer
